// ---- hw/rsp_pkg.sv ----
// Package with constants, types and helpers of the radio SPI access block
// Notes on behaviour
// - Strobe is one header byte, either direction, no burst, address 0x30..0x3D, no data.
// - After a strobe the next byte is again a header, chip select may stay low.
// - Strobes run at once, except power-down and crystal-off, run at chip select rise.
// - Status byte is shifted out while a strobe header is shifted in.
// - Address 0x3F: write reaches transmit FIFO, read reaches receive FIFO.
// - Single FIFO access takes one data byte, then a new header follows.
// - Burst FIFO access moves data bytes until chip select rises.
// - Headers 0x3F, 0x7F, 0xBF, 0xFF select single/burst transmit write, receive read.
// - Transmit write shows free count before storing the byte in progress.
// - Flush strobes empty their FIFO only in idle, underflow or overflow state.
// - Entering sleep empties both FIFOs.
// - Address 0x3E reaches the power table, up to eight data bytes.
// - Table index advances per byte, wraps 7 to 0, clears while chip select high.
// - Table access: write bit zero writes, one reads; burst bit picks single/burst.
// - Entering sleep loses table entries one to seven, entry zero kept.
// - Shared output floats by default, optional status output, serial output while selected.
// - Pin control: device latches clock and data-in at chip select fall.
// - Latched pair 00 power-down, 01 transmit, 10 idle, 11 receive.
// - Pin control only changes state; the active state is not restarted.
// - Pin strobes run at once, except power-down, held until chip select rise.
// - Selected pins act as SPI; selecting in sleep or crystal-off wakes to idle.
// - Status: not-ready bit 7, state bits 6:4, count bits 3:0 saturating at 15.
// - State field 110 after receive overflow, 111 after transmit underflow, until flush of that FIFO or any strobe that picks a new state.
// - In 0x30..0x3D the burst bit picks status read over strobe.
package rsp_pkg;

  // Header layout and address map
  localparam int         RSP_HDR_RW_BIT    = 7;
  localparam int         RSP_HDR_BURST_BIT = 6;
  localparam logic [5:0] RSP_ADDR_STB_LO   = 6'h30;
  localparam logic [5:0] RSP_ADDR_STB_HI   = 6'h3d;
  localparam logic [5:0] RSP_ADDR_PA       = 6'h3e;
  localparam logic [5:0] RSP_ADDR_FIFO     = 6'h3f;

  // Strobe codes inside the strobe range
  localparam logic [5:0] RSP_STB_IDLE  = 6'h30;
  localparam logic [5:0] RSP_STB_RX    = 6'h31;
  localparam logic [5:0] RSP_STB_TX    = 6'h32;
  localparam logic [5:0] RSP_STB_PWD   = 6'h33;
  localparam logic [5:0] RSP_STB_CRYSTAL_OFF_STATE  = 6'h34;
  localparam logic [5:0] RSP_STB_FRX   = 6'h35;
  localparam logic [5:0] RSP_STB_FTX   = 6'h36;

  // Sizes and fixed values
  localparam int         RSP_FIFO_AW      = 6;
  localparam int         RSP_PA_ENTRIES   = 8;
  localparam int         RSP_CNT_SAT      = 15;
  localparam logic [7:0] RSP_STAT_RD_VAL  = 8'h00;

  // Status state field codes
  localparam logic [2:0] RSP_FLD_IDLE = 3'h0;
  localparam logic [2:0] RSP_FLD_RX   = 3'h1;
  localparam logic [2:0] RSP_FLD_TX   = 3'h2;
  localparam logic [2:0] RSP_FLD_OVF  = 3'h6;
  localparam logic [2:0] RSP_FLD_UNF  = 3'h7;

  // Pin control codes, clock level then data-in level
  localparam logic [1:0] RSP_PIN_PWD  = 2'h0;
  localparam logic [1:0] RSP_PIN_TX   = 2'h1;
  localparam logic [1:0] RSP_PIN_IDLE = 2'h2;
  localparam logic [1:0] RSP_PIN_RX   = 2'h3;

  typedef enum logic {RSP_ACC_HDR = 1'b0, RSP_ACC_DATA = 1'b1} rsp_acc_type;

  typedef enum logic [2:0] {
    RSP_M_CFG = 3'b000, RSP_M_TXF = 3'b001, RSP_M_RXF = 3'b011,
    RSP_M_PA  = 3'b010, RSP_M_STAT = 3'b110
  } rsp_mode_type;

  typedef enum logic [2:0] {
    RSP_R_IDLE = 3'b000, RSP_R_RX = 3'b001, RSP_R_RXOVF = 3'b011, RSP_R_TX = 3'b010,
    RSP_R_TXUNF = 3'b110, RSP_R_SLEEP = 3'b100, RSP_R_CRYSTAL_OFF_STATE = 3'b101
  } rsp_radio_type;

  // Count field of the status byte, saturating
  function automatic logic [3:0] rsp_sat_count(input int cnt);
    return (cnt > RSP_CNT_SAT) ? 4'hf : cnt[3:0];
  endfunction

  // State field of the status byte; sleep states report idle with not-ready set
  function automatic logic [2:0] rsp_state_field(input rsp_radio_type r);
    case (r)
      RSP_R_RX:    return RSP_FLD_RX;
      RSP_R_TX:    return RSP_FLD_TX;
      RSP_R_RXOVF: return RSP_FLD_OVF;
      RSP_R_TXUNF: return RSP_FLD_UNF;
      default:     return RSP_FLD_IDLE;
    endcase
  endfunction

endpackage

// ---- hw/rsp_spi_access.sv ----
`timescale 1ns/1ps
// Core-clock side: header decode, strobes, FIFOs, power table and pin control
module rsp_spi_access
  import rsp_pkg::*;
#(
  parameter int FIFO_AW = RSP_FIFO_AW
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       si,
  output logic            so_out,
  output logic            so_oe_n,
  input  wire logic       pin_radio_control_enable,
  input  wire logic [2:0] output_level_select,
  input  wire logic       general_status_enable,
  input  wire logic       general_status_level,
  input  wire logic       tx_pop,
  output logic [7:0]      tx_data,
  output logic            tx_empty,
  input  wire logic       rx_push,
  input  wire logic [7:0] rx_data,
  output logic            rx_full,
  output logic [2:0]      radio_state_field,
  output logic            chip_not_ready,
  output logic [7:0]      pa_setting
);

  localparam int               DEPTH    = 2 ** FIFO_AW;
  localparam logic [FIFO_AW:0] FULL_CNT = (FIFO_AW + 1)'(DEPTH);

  typedef struct packed {
    logic                            cs_m;
    logic                            cs_s;
    logic                            cs_q;
    logic                            sclk_m;
    logic                            sclk_s;
    logic                            si_m;
    logic                            si_s;
    logic                            tgl_m;
    logic                            tgl_s;
    logic                            tgl_seen;
    rsp_acc_type                     acc;
    rsp_mode_type                    mode;
    logic                            rw;
    logic                            burst;
    rsp_radio_type                   radio;
    logic                            pend_pwd;
    logic                            pend_crystal_off_state;
    logic [2:0]                      pa_idx;
    logic [RSP_PA_ENTRIES-1:0][7:0]  pa;
    logic [DEPTH-1:0][7:0]           txm;
    logic [DEPTH-1:0][7:0]           rxm;
    logic [FIFO_AW:0]                tx_wr;
    logic [FIFO_AW:0]                tx_rd;
    logic [FIFO_AW:0]                rx_wr;
    logic [FIFO_AW:0]                rx_rd;
    logic [7:0]                      so_byte;
  } rsp_state_type;

  rsp_state_type    s_ff;
  rsp_state_type    nxt_s;
  logic [7:0]       link_byte;
  logic             link_tgl;
  logic [FIFO_AW:0] tx_cnt;
  logic [FIFO_AW:0] rx_cnt;
  logic             byte_ev;
  logic             cs_rise;
  logic             cs_fall;
  logic             hdr_strobe;

  // Serial-clock domain; its byte word is read only after the toggle crossing
  rsp_spi_link u_link (
    .sclk       (sclk),
    .nrst       (nrst),
    .cs_n       (cs_n),
    .si         (si),
    .tx_byte    (s_ff.so_byte),
    .gen_enable (general_status_enable),
    .gen_level  (general_status_level),
    .so_out     (so_out),
    .so_oe_n    (so_oe_n),
    .rx_byte    (link_byte),
    .rx_tgl     (link_tgl)
  );

  // Events derived from synchronised pins; toggle is ignored while deselected
  assign tx_cnt = s_ff.tx_wr - s_ff.tx_rd;
  assign rx_cnt = s_ff.rx_wr - s_ff.rx_rd;
  assign byte_ev = (s_ff.tgl_s != s_ff.tgl_seen) && !s_ff.cs_s;
  assign cs_rise = !s_ff.cs_q && s_ff.cs_s;
  assign cs_fall = s_ff.cs_q && !s_ff.cs_s;
  assign hdr_strobe = byte_ev && (s_ff.acc == RSP_ACC_HDR) && !link_byte[RSP_HDR_BURST_BIT]
                      && (link_byte[5:0] >= RSP_ADDR_STB_LO) && (link_byte[5:0] <= RSP_ADDR_STB_HI);

  // Flushes are only honoured where the radio is parked
  function automatic logic flush_ok(input rsp_radio_type r);
    return (r == RSP_R_IDLE) || (r == RSP_R_TXUNF) || (r == RSP_R_RXOVF);
  endfunction

  // Enter sleep: empty both FIFOs, keep only the first table entry
  function automatic rsp_state_type enter_sleep(input rsp_state_type st);
    rsp_state_type r;
    r = st;
    r.radio = RSP_R_SLEEP;
    r.tx_rd = r.tx_wr;
    r.rx_rd = r.rx_wr;
    for (int i = 1; i < RSP_PA_ENTRIES; i++) begin
      r.pa[i] = 8'h00;
    end
    return r;
  endfunction

  // Execute one strobe; power-down and crystal-off only arm for chip select rise
  function automatic rsp_state_type apply_strobe(input rsp_state_type st, input logic [5:0] code);
    rsp_state_type r;
    r = st;
    case (code)
      RSP_STB_IDLE: r.radio = RSP_R_IDLE;
      RSP_STB_RX:   r.radio = RSP_R_RX;
      RSP_STB_TX:   r.radio = RSP_R_TX;
      RSP_STB_PWD:  r.pend_pwd = 1'b1;
      RSP_STB_CRYSTAL_OFF_STATE: r.pend_crystal_off_state = 1'b1;
      // flush in permitted states; otherwise left alone; leaves only the error state of its own FIFO
      RSP_STB_FRX: begin
        if (flush_ok(st.radio)) begin
          r.rx_rd = r.rx_wr;
          if (st.radio == RSP_R_RXOVF) begin
            r.radio = RSP_R_IDLE;
          end
        end
      end
      RSP_STB_FTX: begin
        if (flush_ok(st.radio)) begin
          r.tx_rd = r.tx_wr;
          if (st.radio == RSP_R_TXUNF) begin
            r.radio = RSP_R_IDLE;
          end
        end
      end
      default: ;
    endcase
    return r;
  endfunction

  // Status byte: write headers count free transmit room, reads count receive bytes
  function automatic logic [7:0] status_byte(input rsp_state_type st);
    logic [FIFO_AW:0] cnt;
    cnt = st.rw ? (st.rx_wr - st.rx_rd) : (FULL_CNT - (st.tx_wr - st.tx_rd));
    return {(st.radio == RSP_R_SLEEP) || (st.radio == RSP_R_CRYSTAL_OFF_STATE),
            rsp_state_field(st.radio), rsp_sat_count(int'(cnt))};
  endfunction

  // Pin control code to strobe, and the state that strobe leads to
  function automatic logic [5:0] pin_code(input logic [1:0] p);
    case (p)
      RSP_PIN_PWD:  return RSP_STB_PWD;
      RSP_PIN_TX:   return RSP_STB_TX;
      RSP_PIN_IDLE: return RSP_STB_IDLE;
      default:      return RSP_STB_RX;
    endcase
  endfunction

  function automatic rsp_radio_type pin_target(input logic [1:0] p);
    case (p)
      RSP_PIN_PWD:  return RSP_R_SLEEP;
      RSP_PIN_TX:   return RSP_R_TX;
      RSP_PIN_IDLE: return RSP_R_IDLE;
      default:      return RSP_R_RX;
    endcase
  endfunction

  // Whole next-state computation
  always_comb begin
    logic [1:0] pins;
    pins = {s_ff.sclk_s, s_ff.si_s};
    nxt_s = s_ff;
    // Two-stage synchronisers for pins and the byte toggle
    nxt_s.cs_m = cs_n;
    nxt_s.cs_s = s_ff.cs_m;
    nxt_s.cs_q = s_ff.cs_s;
    nxt_s.sclk_m = sclk;
    nxt_s.sclk_s = s_ff.sclk_m;
    nxt_s.si_m = si;
    nxt_s.si_s = s_ff.si_m;
    nxt_s.tgl_m = link_tgl;
    nxt_s.tgl_s = s_ff.tgl_m;
    nxt_s.tgl_seen = s_ff.tgl_s;

    // Radio side drains transmit and fills receive; empty pop in transmit, full push in receive move to error states
    if (tx_pop) begin
      if (tx_cnt == '0) begin
        if (s_ff.radio == RSP_R_TX) begin
          nxt_s.radio = RSP_R_TXUNF;
        end
      end else begin
        nxt_s.tx_rd = s_ff.tx_rd + 1'b1;
      end
    end
    if (rx_push) begin
      if (rx_cnt == FULL_CNT) begin
        if (s_ff.radio == RSP_R_RX) begin
          nxt_s.radio = RSP_R_RXOVF;
        end
      end else begin
        nxt_s.rxm[s_ff.rx_wr[FIFO_AW-1:0]] = rx_data;
        nxt_s.rx_wr = s_ff.rx_wr + 1'b1;
      end
    end

    if (byte_ev && (s_ff.acc == RSP_ACC_HDR)) begin
      // Header decode
      nxt_s.rw = link_byte[RSP_HDR_RW_BIT];
      nxt_s.burst = link_byte[RSP_HDR_BURST_BIT];
      nxt_s.acc = RSP_ACC_DATA;
      nxt_s.mode = RSP_M_CFG;
      if (hdr_strobe) begin
        // strobe has no data, header follows
        nxt_s.acc = RSP_ACC_HDR;
        nxt_s = apply_strobe(nxt_s, link_byte[5:0]);
      end else if ((link_byte[5:0] >= RSP_ADDR_STB_LO) && (link_byte[5:0] <= RSP_ADDR_STB_HI)) begin
        nxt_s.mode = RSP_M_STAT;
      end else if (link_byte[5:0] == RSP_ADDR_PA) begin
        nxt_s.mode = RSP_M_PA;
      end else if (link_byte[5:0] == RSP_ADDR_FIFO) begin
        nxt_s.mode = link_byte[RSP_HDR_RW_BIT] ? RSP_M_RXF : RSP_M_TXF;
      end
    end else if (byte_ev) begin
      // Data byte; writes beyond a full transmit FIFO are dropped
      case (s_ff.mode)
        RSP_M_TXF: begin
          if (tx_cnt != FULL_CNT) begin
            nxt_s.txm[s_ff.tx_wr[FIFO_AW-1:0]] = link_byte;
            nxt_s.tx_wr = s_ff.tx_wr + 1'b1;
          end
        end
        RSP_M_RXF: begin
          if (rx_cnt != '0) begin
            nxt_s.rx_rd = s_ff.rx_rd + 1'b1;
          end
        end
        RSP_M_PA: begin
          if (!s_ff.rw) begin
            nxt_s.pa[s_ff.pa_idx] = link_byte;
          end
          nxt_s.pa_idx = s_ff.pa_idx + 3'h1;
        end
        default: ;
      endcase
      // single access and status read end after one byte; other bursts run until deselect
      if (!s_ff.burst || (s_ff.mode == RSP_M_STAT)) begin
        nxt_s.acc = RSP_ACC_HDR;
      end
    end

    if (s_ff.cs_s) begin
      nxt_s.acc = RSP_ACC_HDR;
      nxt_s.pa_idx = 3'h0;
    end

    // deferred strobes run at chip select rise; power-down wins
    if (cs_rise) begin
      if (s_ff.pend_pwd) begin
        nxt_s = enter_sleep(nxt_s);
      end else if (s_ff.pend_crystal_off_state) begin
        nxt_s.radio = RSP_R_CRYSTAL_OFF_STATE;
      end
      nxt_s.pend_pwd = 1'b0;
      nxt_s.pend_crystal_off_state = 1'b0;
    end

    if (cs_fall) begin
      // selecting wakes the chip to idle
      if ((nxt_s.radio == RSP_R_SLEEP) || (nxt_s.radio == RSP_R_CRYSTAL_OFF_STATE)) begin
        nxt_s.radio = RSP_R_IDLE;
      end
      // latched pins give a strobe only when the state would change
      if (pin_radio_control_enable && (pin_target(pins) != nxt_s.radio)) begin
        nxt_s = apply_strobe(nxt_s, pin_code(pins));
      end
    end

    // next word to shift out: read data, else status with current counts
    if ((nxt_s.acc == RSP_ACC_DATA) && nxt_s.rw) begin
      case (nxt_s.mode)
        RSP_M_RXF: nxt_s.so_byte = nxt_s.rxm[nxt_s.rx_rd[FIFO_AW-1:0]];
        RSP_M_PA:  nxt_s.so_byte = nxt_s.pa[nxt_s.pa_idx];
        default:   nxt_s.so_byte = RSP_STAT_RD_VAL;
      endcase
    end else begin
      nxt_s.so_byte = status_byte(nxt_s);
    end
  end

  // Single state register; table contents are lost only through sleep or reset
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs toward the radio core
  assign tx_data = s_ff.txm[s_ff.tx_rd[FIFO_AW-1:0]];
  assign tx_empty = (tx_cnt == '0);
  assign rx_full = (rx_cnt == FULL_CNT);
  assign radio_state_field = rsp_state_field(s_ff.radio);
  assign chip_not_ready = (s_ff.radio == RSP_R_SLEEP) || (s_ff.radio == RSP_R_CRYSTAL_OFF_STATE);
  assign pa_setting = s_ff.pa[output_level_select];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_strobe_then_hdr: assert property (hdr_strobe |=> s_ff.acc == RSP_ACC_HDR)
    else $error("strobe header not followed by header state");
  a_pwd_deferred: assert property (hdr_strobe && link_byte[5:0] == RSP_STB_PWD
      && !cs_rise |=> s_ff.pend_pwd && s_ff.radio != RSP_R_SLEEP)
    else $error("power-down strobe acted before deselect");
  a_sleep_flush: assert property (cs_rise && s_ff.pend_pwd
      |=> s_ff.radio == RSP_R_SLEEP && tx_cnt == '0 && rx_cnt == '0)
    else $error("sleep entry did not flush both FIFOs");
  a_flush_tx_ok: assert property (hdr_strobe && link_byte[5:0] == RSP_STB_FTX
      && s_ff.radio == RSP_R_IDLE && !cs_fall |=> tx_cnt == '0)
    else $error("transmit flush in idle left data");
  a_flush_ignored: assert property (hdr_strobe && link_byte[5:0] == RSP_STB_FTX
      && s_ff.radio == RSP_R_RX && !tx_pop |=> $stable(s_ff.tx_rd))
    else $error("flush outside permitted state changed FIFO");
  a_pa_idx_clear: assert property (s_ff.cs_s |=> s_ff.pa_idx == 3'h0)
    else $error("table index not cleared while deselected");
  a_pa_keep_zero: assert property (s_ff.radio != RSP_R_SLEEP ##1 s_ff.radio == RSP_R_SLEEP
      |-> s_ff.pa[0] == $past(s_ff.pa[0]) && s_ff.pa[1] == 8'h00)
    else $error("table entries wrong after sleep entry");
  a_rx_overflow: assert property (rx_push && rx_full && s_ff.radio == RSP_R_RX
      && !byte_ev && !cs_fall |=> s_ff.radio == RSP_R_RXOVF [*2])
    else $error("receive overflow state not reached or not held");
  a_single_fifo: assert property (byte_ev && s_ff.acc == RSP_ACC_DATA && s_ff.mode == RSP_M_TXF
      && !s_ff.burst |=> s_ff.acc == RSP_ACC_HDR)
    else $error("single FIFO access took more than one byte");
  a_pin_rx: assert property (cs_fall && pin_radio_control_enable && s_ff.sclk_s && s_ff.si_s
      && s_ff.radio == RSP_R_IDLE |=> s_ff.radio == RSP_R_RX)
    else $error("pin control receive code not applied");
  a_wake_idle: assert property (cs_fall && !pin_radio_control_enable
      && s_ff.radio == RSP_R_SLEEP |=> s_ff.radio == RSP_R_IDLE)
    else $error("selection did not wake from sleep");
  a_status_field: assert property (s_ff.acc == RSP_ACC_HDR
      |-> s_ff.so_byte[6:4] == radio_state_field && s_ff.so_byte[7] == chip_not_ready)
    else $error("status byte fields disagree with state");

  c_strobe: cover property (hdr_strobe);
  c_burst_tx: cover property (byte_ev && s_ff.mode == RSP_M_TXF && s_ff.burst
      && s_ff.acc == RSP_ACC_DATA ##[1:200] byte_ev);
  c_pa_wrap: cover property (byte_ev && s_ff.mode == RSP_M_PA && s_ff.pa_idx == 3'h7);
  c_pin_ctrl: cover property (cs_fall && pin_radio_control_enable);

endmodule

// ---- hw/rsp_spi_link.sv ----
`timescale 1ns/1ps
// Serial-clock side of the SPI: byte shifter, status output, shared pin drive
module rsp_spi_link
  import rsp_pkg::*;
(
  input  wire logic       sclk,
  input  wire logic       nrst,
  input  wire logic       cs_n,
  input  wire logic       si,
  input  wire logic [7:0] tx_byte,
  input  wire logic       gen_enable,
  input  wire logic       gen_level,
  output logic            so_out,
  output logic            so_oe_n,
  output logic [7:0]      rx_byte,
  output logic            rx_tgl
);

  typedef struct packed {
    logic [2:0] cnt;
    logic [6:0] sh_in;
    logic [7:0] sh_out;
    logic [7:0] rx_byte;
    logic       tgl;
  } rsp_link_type;

  rsp_link_type s_ff;
  rsp_link_type nxt_s;
  logic         link_rst_n;

  // Deselect clears the shifter; the core ignores the toggle while deselected
  assign link_rst_n = nrst & ~cs_n;

  // Shift in on each rising edge, hand a whole byte over by toggle
  always_comb begin
    nxt_s = s_ff;
    nxt_s.sh_in = {s_ff.sh_in[5:0], si};
    nxt_s.cnt = s_ff.cnt + 3'h1;
    nxt_s.sh_out = (s_ff.cnt == 3'h0) ? {tx_byte[6:0], 1'b0} : {s_ff.sh_out[6:0], 1'b0};
    if (s_ff.cnt == 3'h7) begin
      nxt_s.rx_byte = {s_ff.sh_in, si};
      nxt_s.tgl = ~s_ff.tgl;
    end
  end

  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // status out: first bit straight from the core word, rest from the shifter
  // shared pin: serial output while selected, else optional status level
  always_comb begin
    if (cs_n) begin
      so_out = gen_level;
      so_oe_n = ~gen_enable;
    end else begin
      so_out = (s_ff.cnt == 3'h0) ? tx_byte[7] : s_ff.sh_out[7];
      so_oe_n = 1'b0;
    end
  end

  assign rx_byte = s_ff.rx_byte;
  assign rx_tgl = s_ff.tgl;

endmodule

// ---- verification/rsp_host_model.sv ----
`timescale 1ns/1ps
// Host SPI master model; its clock stands still between frames
module rsp_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so_out,
  input  wire logic so_oe_n
);
  // Deselected, clock low
  initial {sclk, cs_n, si} = 3'b010;
  task automatic pin_sel(input logic c, input logic s);
    {sclk, si} = {c, s};
    #40 cs_n = 1'b0;
    #80;
  endtask
  // Quiet time around the rise keeps the last byte whole
  task automatic desel();
    #80 {cs_n, sclk, si} = {2'b10, ~si};
    // Whole multiple of the core period keeps later checks off the rising edge
    #104;
  endtask
  // whole bytes, MSB first, answer taken at each rise
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      si = d[i];
      #7.5 q[i] = so_oe_n ? 1'bz : so_out;
      sclk = 1'b1;
      #7.5 sclk = (i == 0);
    end
    #80 {sclk, si} = {1'b0, ~si};
  endtask
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the radio SPI access block
module tb;
  import rsp_pkg::*;
  logic       mclk, nrst, sclk, cs_n, si, so_out, so_oe_n, tx_pop, tx_empty;
  logic       rx_push, rx_full, pin_radio_control_enable, gs_en, gs_lvl, chip_not_ready;
  logic [2:0] output_level_select, radio_state_field;
  logic [7:0] tx_data, rx_data, pa_setting, q;
  int         errors = 0;
  int         checked = 0;
  // Four-deep FIFOs make full and empty cheap to reach
  rsp_spi_access #(.FIFO_AW(2)) rsp_spi_access_i (.mclk(mclk), .nrst(nrst), .sclk(sclk),
    .cs_n(cs_n), .si(si), .so_out(so_out), .so_oe_n(so_oe_n),
    .pin_radio_control_enable(pin_radio_control_enable),
    .output_level_select(output_level_select), .general_status_enable(gs_en),
    .general_status_level(gs_lvl), .tx_pop(tx_pop), .tx_data(tx_data), .tx_empty(tx_empty),
    .rx_push(rx_push), .rx_data(rx_data), .rx_full(rx_full),
    .radio_state_field(radio_state_field), .chip_not_ready(chip_not_ready),
    .pa_setting(pa_setting));
  rsp_host_model rsp_host_model_i (.sclk(sclk), .cs_n(cs_n), .si(si), .so_out(so_out),
    .so_oe_n(so_oe_n));
  // Core clock; host tasks last multiples of 8 ns so checks land on falling edges
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic sx(input logic [7:0] d, input logic [7:0] e);
    rsp_host_model_i.xfer(d, q);
    chk(q, e);
  endtask
  task automatic tx(input logic [7:0] d);
    rsp_host_model_i.xfer(d, q);
  endtask
  task automatic sel();
    rsp_host_model_i.pin_sel(1'b0, 1'b0);
  endtask
  task automatic ds();
    rsp_host_model_i.desel();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic pop();
    @(posedge mclk) tx_pop <= 1'b1;
    @(posedge mclk) tx_pop <= 1'b0;
    cyc(3);
  endtask
  task automatic push(input logic [7:0] d);
    @(posedge mclk) rx_push <= 1'b1;
    rx_data <= d;
    @(posedge mclk) rx_push <= 1'b0;
    cyc(1);
  endtask
  // Pin strobe must act while still selected, not at the rise
  task automatic pc(input logic c, input logic s, input logic [2:0] f);
    rsp_host_model_i.pin_sel(c, s);
    chk(radio_state_field, f);
    ds();
  endtask
  // Main sequence
  initial begin
    {nrst, tx_pop, rx_push, rx_data, gs_en, gs_lvl} = '0;
    pin_radio_control_enable = 1'b0;
    output_level_select = 3'h0;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    cyc(5);
    chk({tx_empty, rx_full, chip_not_ready, radio_state_field, so_oe_n}, 8'h41);
    sel();
    chk(so_oe_n, 8'h00);
    sx(8'h31, 8'h04);
    chk(radio_state_field, RSP_FLD_RX);
    sx(8'h30, 8'h14);
    // Status read needs read and burst set; header status counts by the previous direction
    sx(8'hf1, 8'h04);
    sx(8'h00, 8'h00);
    chk(radio_state_field, RSP_FLD_IDLE);
    sx(8'h7f, 8'h00);
    for (int i = 0; i < 5; i++) begin
      sx(8'ha0 + 8'(i), 8'h04 - 8'(i));
    end
    ds();
    for (int i = 0; i < 4; i++) begin
      chk(tx_data, 8'ha0 + 8'(i));
      pop();
    end
    sel();
    sx(8'h3f, 8'h04);
    sx(8'h5a, 8'h04);
    sx(8'h3f, 8'h03);
    tx(8'h69);
    sx(8'h31, 8'h02);
    tx(8'h36);
    ds();
    chk(tx_empty, 8'h00);
    sel();
    tx(8'h30);
    tx(8'h36);
    ds();
    chk(tx_empty, 8'h01);
    sel();
    tx(8'h31);
    ds();
    for (int i = 0; i < 5; i++) begin
      push(8'hc0 + 8'(i));
    end
    chk({rx_full, radio_state_field}, 8'h0e);
    sel();
    tx(8'hbf);
    sx(8'h00, 8'hc0);
    tx(8'hff);
    sx(8'h00, 8'hc1);
    sx(8'h00, 8'hc2);
    ds();
    sel();
    tx(8'h35);
    tx(8'h32);
    ds();
    chk({rx_full, radio_state_field}, 8'h02);
    pop();
    chk(radio_state_field, RSP_FLD_UNF);
    sel();
    tx(8'h36);
    ds();
    chk(radio_state_field, RSP_FLD_IDLE);
    sel();
    tx(8'h7e);
    for (int i = 0; i < 9; i++) begin
      tx(8'h10 + 8'(i));
    end
    ds();
    sel();
    tx(8'hfe);
    for (int i = 0; i < 8; i++) begin
      sx(8'h00, (i == 0) ? 8'h18 : 8'h10 + 8'(i));
    end
    ds();
    for (int i = 7; i >= 0; i--) begin
      @(posedge mclk) output_level_select <= 3'(i);
      cyc(2);
      chk(pa_setting, (i == 0) ? 8'h18 : 8'h10 + 8'(i));
    end
    sel();
    tx(8'h3f);
    tx(8'h55);
    tx(8'h33);
    chk(chip_not_ready, 8'h00);
    ds();
    chk(pa_setting, 8'h18);
    chk({chip_not_ready, tx_empty}, 8'h03);
    @(posedge mclk) output_level_select <= 3'h1;
    cyc(2);
    chk(pa_setting, 8'h00);
    sel();
    chk(chip_not_ready, 8'h00);
    tx(8'h34);
    ds();
    chk(chip_not_ready, 8'h01);
    sel();
    ds();
    @(posedge mclk) pin_radio_control_enable <= 1'b1;
    cyc(1);
    pc(1'b1, 1'b1, RSP_FLD_RX);
    pc(1'b0, 1'b1, RSP_FLD_TX);
    pc(1'b1, 1'b0, RSP_FLD_IDLE);
    rsp_host_model_i.pin_sel(1'b0, 1'b0);
    chk(chip_not_ready, 8'h00);
    ds();
    chk(chip_not_ready, 8'h01);
    pc(1'b1, 1'b1, RSP_FLD_RX);
    pc(1'b1, 1'b1, RSP_FLD_RX);
    @(posedge mclk) gs_en <= 1'b1;
    gs_lvl <= 1'b1;
    cyc(2);
    chk({so_oe_n, so_out}, 8'h01);
    end_sim();
  end
endmodule
